// ==== pkg/dcd_pkg.sv ====
`default_nettype none
package dcd_pkg;
  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned BANK_W        = 2;
  localparam int unsigned NBANK         = 4;
  localparam int unsigned COL_W         = 10;
  localparam int unsigned DQ_W          = 16;
  localparam int unsigned DM_W          = 2;
  localparam int unsigned AP_BIT        = 10;
  localparam int unsigned ROW_TOP_BIT   = 13;
  localparam int unsigned CKE_HOLD_CLK  = 3;
  localparam int unsigned XSRD_CLK      = 200;
  localparam int unsigned BURST4        = 4;
  localparam int unsigned ODT_EN_BIT0   = 2;
  localparam int unsigned ODT_EN_BIT1   = 6;
  localparam logic [1:0]  EMR1_SEL      = 2'h1;
  localparam logic [3:0]  RST_MASK      = 4'h0;

  // ---------------------------------------------------------------
  // Command codes {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DCD_C_MRS = 4'b0000,
    DCD_C_REF = 4'b0001,
    DCD_C_PRE = 4'b0010,
    DCD_C_ACT = 4'b0011,
    DCD_C_WR  = 4'b0100,
    DCD_C_RD  = 4'b0101,
    DCD_C_NOP = 4'b0111,
    DCD_C_DES = 4'b1111
  } dcd_cmd_e;

  typedef enum logic [2:0] {
    DCD_S_IDLE  = 3'b000,
    DCD_S_ACTV  = 3'b001,
    DCD_S_APD   = 3'b010,
    DCD_S_PPD   = 3'b011,
    DCD_S_SREF  = 3'b100
  } dcd_state_e;

  // Host order codes
  typedef enum logic [2:0] {
    DCD_O_NONE = 3'b000,
    DCD_O_MRS  = 3'b001,
    DCD_O_ACT  = 3'b010,
    DCD_O_PRE  = 3'b011,
    DCD_O_WR   = 3'b100,
    DCD_O_RD   = 3'b101,
    DCD_O_REF  = 3'b110
  } dcd_op_e;

  // ---------------------------------------------------------------
  // Host registers on APB (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_PWR    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_WDATA  = 8'h10;

  function automatic logic is_nop_des(input logic [3:0] c);
    return c[3] || (c == DCD_C_NOP);
  endfunction : is_nop_des
endpackage : dcd_pkg
`default_nettype wire

// ==== pkg/dcd_if.sv ====
`default_nettype none
interface dcd_if;
  import dcd_pkg::*;
  logic                cke;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BANK_W-1:0]   ba;
  logic [ADDR_W-1:0]   addr;
  logic                odt;
  logic [DQ_W-1:0]     dq;
  logic [DM_W-1:0]     dm;
  logic                dvalid;
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm, dvalid);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dq, dm, dvalid);
endinterface : dcd_if
`default_nettype wire

// ==== rtl/dcd_bank_track.sv ====
`default_nettype none
module dcd_bank_track
  import dcd_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              act,
  input  wire logic              pre,
  input  wire logic              pre_all,
  input  wire logic [BANK_W-1:0] bank,
  output logic      [NBANK-1:0]  open_q
);
  logic [NBANK-1:0] open_d;

  // One tracker per bank
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      always_comb begin
        open_d[g] = open_q[g];
        if (pre && (pre_all || bank == BANK_W'(g))) begin
          open_d[g] = 1'b0;
        end
        if (act && bank == BANK_W'(g)) begin
          open_d[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= RST_MASK;
    end else begin
      open_q <= open_d;
    end
  end
endmodule : dcd_bank_track
`default_nettype wire

// ==== rtl/dcd_mem.sv ====
`default_nettype none
module dcd_mem
  import dcd_pkg::*;
#(
  parameter bit X16 = 1'b1
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  dcd_if.mem                       bus,
  output logic [2:0]               state,
  output logic [NBANK-1:0]         banks_open,
  output logic [ADDR_W-1:0]        mr0,
  output logic [ADDR_W-1:0]        mr1,
  output logic                     odt_on,
  output logic                     illegal,
  output logic                     wr_start,
  output logic                     rd_start,
  output logic [COL_W-1:0]         col,
  output logic                     auto_pre,
  output logic [DQ_W-1:0]          wr_word,
  output logic                     burst_busy
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                            cke_prev;
    dcd_state_e                      st;
    logic [3:0][ADDR_W-1:0]          mr;
    logic [NBANK-1:0][ADDR_W-1:0]    row;
    logic                            odt;
    logic                            ill;
    logic                            wr;
    logic                            rd;
    logic [COL_W-1:0]                col;
    logic                            ap;
    logic [2:0]                      beats;
    logic                            wdir;
    logic [DQ_W-1:0]                 wword;
    logic                            busy;
  } dcd_mem_s;

  dcd_mem_s s_q, s_d;
  logic [3:0]             cmd;
  logic                   is_act, is_pre;
  logic [NBANK-1:0]       open_q;
  logic [ADDR_W-1:0]      row_in;

  // A command counts only with clock enable high on this edge and the last
  function automatic logic live_cmd(input logic [3:0] c, input logic [3:0] want, input logic prev_en,
                                    input logic now_en);
    return prev_en && now_en && (c == want);
  endfunction : live_cmd

  // Pin order cs_n, ras_n, cas_n, we_n; termination never enters the code
  assign cmd    = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  // Bank changes use the same live test as the decode below
  assign is_act = live_cmd(cmd, DCD_C_ACT, s_q.cke_prev, bus.cke) && s_q.st != DCD_S_SREF;
  assign is_pre = live_cmd(cmd, DCD_C_PRE, s_q.cke_prev, bus.cke) && s_q.st != DCD_S_SREF;

  always_comb begin
    row_in = bus.addr;
    // The wide part has one row bit fewer
    if (X16) begin
      row_in[ROW_TOP_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bank tracking
  // ---------------------------------------------------------------
  dcd_bank_track u_banks (
    .pclk    (pclk),
    .presetn (presetn),
    .act     (is_act),
    .pre     (is_pre),
    .pre_all (bus.addr[AP_BIT]),
    .bank    (bus.ba),
    .open_q  (open_q)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.cke_prev = bus.cke;
    // Start and error flags are one-cycle pulses
    s_d.wr       = 1'b0;
    s_d.rd       = 1'b0;
    s_d.ill      = 1'b0;
    // Termination follows its pin except in self refresh; decode ignores it
    s_d.odt      = bus.odt && s_q.st != DCD_S_SREF && !(s_q.cke_prev && !bus.cke
                   && cmd == DCD_C_REF);
    // Burst runs to its end regardless of later commands
    if (s_q.beats != 3'h0) begin
      s_d.beats = s_q.beats - 3'h1;
    end
    // Each beat writes only the bytes whose mask is low
    if (s_q.wdir && s_q.beats != 3'h0 && bus.dvalid) begin
      for (int b = 0; b < DM_W; b++) begin
        if (!bus.dm[b]) begin
          s_d.wword[b*8 +: 8] = bus.dq[b*8 +: 8];
        end
      end
    end
    case (s_q.st)
      DCD_S_IDLE, DCD_S_ACTV: begin
        if (s_q.cke_prev && !bus.cke) begin
          if (cmd == DCD_C_REF && open_q == '0) begin
            s_d.st  = DCD_S_SREF;
          end else if (is_nop_des(cmd)) begin
            s_d.st = (open_q != '0) ? DCD_S_APD : DCD_S_PPD;
          end else begin
            s_d.ill = 1'b1;
          end
        end else if (s_q.cke_prev && bus.cke && !bus.cs_n) begin
          case (cmd)
            DCD_C_MRS: s_d.mr[bus.ba] = bus.addr;
            DCD_C_ACT: s_d.row[bus.ba] = row_in;
            DCD_C_WR, DCD_C_RD: begin
              s_d.wr    = !bus.we_n;
              s_d.rd    = bus.we_n;
              s_d.col   = bus.addr[COL_W-1:0];
              s_d.ap    = bus.addr[AP_BIT];
              s_d.wdir  = !bus.we_n;
              if (s_q.beats == 3'h0) begin
                s_d.beats = 3'(BURST4);
              end else begin
                s_d.ill = 1'b1;
              end
            end
            DCD_C_PRE, DCD_C_REF, DCD_C_NOP: ;
            // Remaining selected code is reserved: flag it, start nothing
            default: s_d.ill = 1'b1;
          endcase
        end
        // With no power change, open banks decide between active and idle
        if (s_d.st == s_q.st) begin
          s_d.st = (s_d.st == DCD_S_IDLE || s_d.st == DCD_S_ACTV) &&
                   ((open_q != '0) || is_act) && !(is_pre && (bus.addr[AP_BIT] || open_q ==
                   (NBANK'(1) << bus.ba))) ? DCD_S_ACTV : DCD_S_IDLE;
        end
      end
      // Low-power states: no refresh runs here; only a clean rise leaves
      DCD_S_APD, DCD_S_PPD, DCD_S_SREF: begin
        if (!s_q.cke_prev && bus.cke) begin
          if (is_nop_des(cmd)) begin
            s_d.st = (open_q != '0) ? DCD_S_ACTV : DCD_S_IDLE;
          end else begin
            s_d.ill = 1'b1;
          end
        end
      end
      default: s_d.st = DCD_S_IDLE;
    endcase
    // Busy is registered so the output comes straight from a flop
    s_d.busy = s_d.beats != 3'h0;
  end

  // Whole state clears together; banks start closed in the tracker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign state      = s_q.st;
  assign banks_open = open_q;
  assign mr0        = s_q.mr[0];
  assign mr1        = s_q.mr[EMR1_SEL];
  assign odt_on     = s_q.odt;
  assign illegal    = s_q.ill;
  assign wr_start   = s_q.wr;
  assign rd_start   = s_q.rd;
  assign col        = s_q.col;
  assign auto_pre   = s_q.ap;
  assign wr_word    = s_q.wword;
  assign burst_busy = s_q.busy;
endmodule : dcd_mem
`default_nettype wire

// ==== rtl/dcd_ctl.sv ====
`default_nettype none
module dcd_ctl
  import dcd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dcd_if.ctl               bus
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0]        rdata;
    logic               err;
    logic [3:0]         cmd;
    logic [BANK_W-1:0]  ba;
    logic [ADDR_W-1:0]  addr;
    logic               cke;
    logic               odt;
    logic [1:0]         hold;
    logic [7:0]         xsrd;
    logic               want_cke;
    logic               sref;
    logic [DQ_W-1:0]    dq;
    logic [DM_W-1:0]    dm;
    logic [2:0]         beats;
  } dcd_ctl_s;

  dcd_ctl_s s_q, s_d;
  logic wr_acc;
  logic [2:0] op;

  assign wr_acc = psel && penable && pwrite;
  assign op     = pwdata[2:0];

  function automatic logic reg_mapped(input logic [7:0] a);
    return a inside {REG_CMD, REG_ADDR, REG_PWR, REG_STATUS, REG_WDATA};
  endfunction : reg_mapped

  always_comb begin
    s_d      = s_q;
    s_d.err  = 1'b0;
    s_d.cmd  = DCD_C_NOP;
    if (s_q.hold != 2'h0) begin
      s_d.hold = s_q.hold - 2'h1;
    end
    if (s_q.xsrd != 8'h0) begin
      s_d.xsrd = s_q.xsrd - 8'h1;
    end
    if (s_q.beats != 3'h0) begin
      s_d.beats = s_q.beats - 3'h1;
    end
    // CKE follows the request once the previous level was held long enough and no burst is running
    if (s_q.want_cke != s_q.cke && s_q.hold == 2'h0 && s_q.beats == 3'h0) begin
      s_d.cke  = s_q.want_cke;
      s_d.hold = 2'(CKE_HOLD_CLK - 1);
      if (!s_q.want_cke && s_q.sref) begin
        s_d.cmd = DCD_C_REF;
      end
      if (s_q.want_cke && s_q.sref) begin
        s_d.xsrd = 8'(XSRD_CLK);
        s_d.sref = 1'b0;
      end
    end
    s_d.rdata = 32'h0;
    // Setup cycle settles read data and refusal, so both stand through the access phase
    if (psel && !penable) begin
      if (!reg_mapped(paddr)) begin
        s_d.err = 1'b1;
      end
      // Orders are refused in power-down or while a burst is running
      if (pwrite && paddr == REG_CMD && (!(s_q.cke && s_q.want_cke)
          || (s_q.beats != 3'h0 && op != DCD_O_NONE)
          || (op == DCD_O_RD && s_q.xsrd != 8'h0))) begin
        s_d.err = 1'b1;
      end
      if (!pwrite) begin
        case (paddr)
          REG_ADDR:   s_d.rdata = {16'h0, s_q.addr[ADDR_W-1:0], s_q.ba};
          REG_PWR:    s_d.rdata = {29'h0, s_q.odt, s_q.sref, s_q.want_cke};
          REG_STATUS: s_d.rdata = {22'h0, s_q.xsrd, s_q.cke, s_q.beats != 3'h0};
          default:    s_d.rdata = 32'h0;
        endcase
      end
    end
    // Access edge: a write lands only here, and only when setup accepted it
    if (wr_acc && !s_q.err) begin
      case (paddr)
        REG_ADDR: begin
          s_d.ba   = pwdata[BANK_W-1:0];
          s_d.addr = pwdata[BANK_W +: ADDR_W];
        end
        REG_PWR: begin
          s_d.want_cke = pwdata[0];
          // A self-refresh stay keeps its flag until the exit has been sent
          s_d.sref     = (pwdata[1] && !pwdata[0]) || (s_q.sref && !s_q.cke);
          s_d.odt      = pwdata[2];
        end
        REG_WDATA: begin
          s_d.dq = pwdata[DQ_W-1:0];
          s_d.dm = pwdata[DQ_W +: DM_W];
        end
        REG_CMD: begin
          case (op)
            DCD_O_MRS: s_d.cmd = DCD_C_MRS;
            DCD_O_ACT: s_d.cmd = DCD_C_ACT;
            DCD_O_PRE: s_d.cmd = DCD_C_PRE;
            DCD_O_REF: s_d.cmd = DCD_C_REF;
            DCD_O_WR, DCD_O_RD: begin
              s_d.cmd   = (op == DCD_O_WR) ? DCD_C_WR : DCD_C_RD;
              s_d.beats = 3'(BURST4 + 1);
            end
            default: s_d.cmd = DCD_C_NOP;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.cmd      <= DCD_C_NOP;
      s_q.dm       <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // Access phase answers after one setup cycle
  assign pready     = psel && penable;
  assign prdata     = s_q.rdata;
  assign pslverr    = psel && penable && s_q.err;
  assign bus.cke    = s_q.cke;
  assign bus.cs_n   = s_q.cmd[3];
  assign bus.ras_n  = s_q.cmd[2];
  assign bus.cas_n  = s_q.cmd[1];
  assign bus.we_n   = s_q.cmd[0];
  assign bus.ba     = s_q.ba;
  assign bus.addr   = s_q.addr;
  assign bus.odt    = s_q.odt;
  assign bus.dq     = s_q.dq;
  assign bus.dm     = s_q.dm;
  assign bus.dvalid = s_q.beats != 3'h0 && s_q.beats <= 3'(BURST4);
endmodule : dcd_ctl
`default_nettype wire

// ==== tb/dcd_chk.sv ====
`default_nettype none
module dcd_chk
  import dcd_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              dvalid,
  input wire logic [2:0]        state,
  input wire logic [NBANK-1:0]  banks_open,
  input wire logic              wr_start,
  input wire logic              rd_start,
  input wire logic              illegal
);
  // ---------------------------------------------------------------
  // Link checks
  // ---------------------------------------------------------------
  logic [3:0] cmd;
  logic       quiet;
  assign cmd   = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n || (cmd == DCD_C_NOP);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A command counts only with clock enable high on both edges
  sequence s_live(logic [3:0] c);
    $past(cke) && cke && (cmd == c);
  endsequence

  cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable changed within three edges");
  pd_cmd_a: assert property ($fell(cke) |-> quiet || cmd == DCD_C_REF)
    else $error("bad command with clock enable falling");
  exit_cmd_a: assert property ($rose(cke) |-> quiet)
    else $error("bad command with clock enable rising");
  wr_go_a: assert property (s_live(DCD_C_WR) |=> wr_start && !rd_start)
    else $error("write not started");
  rd_go_a: assert property (s_live(DCD_C_RD) |=> rd_start && !wr_start)
    else $error("read not started");
  desel_quiet_a: assert property (cs_n |=> !wr_start && !rd_start)
    else $error("deselect started an access");
  act_open_a: assert property (s_live(DCD_C_ACT) |=> banks_open[$past(ba)])
    else $error("activated bank not open");
  pre_all_a: assert property (s_live(DCD_C_PRE) ##0 addr[AP_BIT] |=> banks_open == '0)
    else $error("banks open after precharge all");
  sref_in_a: assert property ($fell(cke) && cmd == DCD_C_REF |=> state == DCD_S_SREF)
    else $error("self refresh not entered");
  pd_kind_a: assert property ($fell(cke) && quiet |=>
      state == ($past(|banks_open) ? DCD_S_APD : DCD_S_PPD))
    else $error("wrong power-down kind");
  pd_stay_a: assert property (state inside {DCD_S_APD, DCD_S_PPD, DCD_S_SREF} && !cke
      |=> $stable(state))
    else $error("left low-power state with clock enable low");
  burst_full_a: assert property (s_live(DCD_C_WR) |=> dvalid [*4])
    else $error("write burst cut short");
  pd_idle_a: assert property ($fell(cke) |-> !dvalid)
    else $error("clock enable dropped during a burst");
  legal_cmd_a: assert property (!illegal)
    else $error("reserved command or state combination seen");
endmodule : dcd_chk
`default_nettype wire

// ==== tb/ddr2_command_and_cke_decode_bench.sv ====
`default_nettype none
module ddr2_command_and_cke_decode_bench
  import dcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk = 1'b0;
  logic              presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [2:0]        state;
  logic [NBANK-1:0]  banks_open;
  logic [ADDR_W-1:0] mr0, mr1, op;
  logic              odt_on, wr_start, rd_start, auto_pre, illegal, burst_busy;
  logic [COL_W-1:0]  col, c;
  logic [DQ_W-1:0]   wr_word, d, prev;
  int                failures, cmp_count;

  dcd_if bus_if ();
  dcd_ctl dcd_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.ctl));
  dcd_mem dcd_mem_i (.pclk(pclk), .presetn(presetn), .bus(bus_if.mem), .state(state),
    .banks_open(banks_open), .mr0(mr0), .mr1(mr1), .odt_on(odt_on), .illegal(illegal), .wr_start(wr_start),
    .rd_start(rd_start), .col(col), .auto_pre(auto_pre), .wr_word(wr_word), .burst_busy(burst_busy));
  dcd_chk dcd_chk_i (.pclk(pclk), .presetn(presetn), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
    .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr),
    .dvalid(bus_if.dvalid), .state(state), .banks_open(banks_open), .wr_start(wr_start),
    .rd_start(rd_start), .illegal(illegal));

  always #10 pclk = ~pclk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Address word is {addr, bank}; the refusal flag is checked here
  task automatic order(input dcd_op_e o, input logic [15:0] aw, input logic e);
    apb(1'b1, REG_ADDR, {16'h0, aw});
    apb(1'b1, REG_CMD, {29'h0, o});
    chk("order refused", 32'(err), 32'(e));
  endtask : order

  // Waits out the three-edge clock-enable hold and any burst
  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask : settle

  task automatic pwr(input logic [2:0] v);
    apb(1'b1, REG_PWR, {29'h0, v});
    settle();
  endtask : pwr

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] m);
    return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
  endfunction : merge

  task automatic final_report();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    failures = 0;
    cmp_count = 0;
    prev = 16'h0;
    void'($urandom(67));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("state", 32'(state), 32'(DCD_S_IDLE));
    order(DCD_O_ACT, 16'h0, 1'b1);
    pwr(3'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("cke", 32'(rd[1]), 32'h1);
    for (int b = 0; b < 2; b++) begin
      op = ADDR_W'($urandom);
      if (b == 1) op[ODT_EN_BIT0] = 1'b1;
      order(DCD_O_MRS, {op, 2'(b)}, 1'b0);
      settle();
      chk("mode reg", 32'(b == 1 ? mr1 : mr0), 32'(op));
    end
    for (int b = 0; b < NBANK; b++) begin
      order(DCD_O_ACT, {ADDR_W'($urandom), 2'(b)}, 1'b0);
      settle();
      chk("bank open", 32'(banks_open[b]), 32'h1);
    end
    for (int m = 0; m < 4; m++) begin
      d = DQ_W'($urandom);
      c = COL_W'($urandom);
      apb(1'b1, REG_WDATA, {14'h0, 2'(m), d});
      order(DCD_O_WR, {4'h0, c, 2'b00}, 1'b0);
      apb(1'b1, REG_CMD, {29'h0, DCD_O_RD});
      chk("cut burst", 32'(err), 32'h1);
      chk("burst busy", 32'(burst_busy), 32'h1);
      settle();
      chk("burst done", 32'(burst_busy), 32'h0);
      prev = merge(prev, d, 2'(m));
      chk("write word", 32'(wr_word), 32'(prev));
      chk("column", 32'(col), 32'(c));
    end
    c = COL_W'($urandom);
    order(DCD_O_RD, {3'h0, 1'b1, c, 2'b01}, 1'b0);
    settle();
    chk("column", 32'(col), 32'(c));
    chk("auto pre", 32'(auto_pre), 32'h1);
    pwr(3'h0);
    chk("state", 32'(state), 32'(DCD_S_APD));
    pwr(3'h1);
    chk("state", 32'(state), 32'(DCD_S_ACTV));
    order(DCD_O_PRE, 16'h0, 1'b0);
    settle();
    chk("bank closed", 32'(banks_open[0]), 32'h0);
    chk("bank kept", 32'(banks_open[3:2]), 32'h3);
    order(DCD_O_PRE, {14'h400, 2'b10}, 1'b0);
    settle();
    chk("banks", 32'(banks_open), 32'h0);
    pwr(3'h0);
    chk("state", 32'(state), 32'(DCD_S_PPD));
    pwr(3'h1);
    chk("state", 32'(state), 32'(DCD_S_IDLE));
    pwr(3'h6);
    chk("state", 32'(state), 32'(DCD_S_SREF));
    chk("odt", 32'(odt_on), 32'h0);
    pwr(3'h5);
    chk("state", 32'(state), 32'(DCD_S_IDLE));
    chk("odt", 32'(odt_on), 32'h1);
    order(DCD_O_RD, 16'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    final_report();
  end
endmodule : ddr2_command_and_cke_decode_bench
`default_nettype wire
